/* File: verilog/frir_regs.sv */
// The implementer's own choice: the strobed register port.
`timescale 1ns/100ps
module frir_regs (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  frir_lookup_if lk ();

  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic count_en_r;
  logic flag_r;
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic ctrl_sel;
  logic stat_sel;
  logic ro_write;
  logic stat_clear;

  // ---------------------------------------------------------------
  // Capability lookup
  // ---------------------------------------------------------------

  // The table answers in the same cycle; only the read data is registered.
  assign lk.ofs = reg_addr;

  frir_caps_table u_table (
    .lk(lk.table_side)
  );

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------

  // Word offsets are compared in full, so misaligned addresses miss.
  assign ctrl_sel = (reg_addr == frir_pkg::OFS_WATCH_CTRL);
  assign stat_sel = (reg_addr == frir_pkg::OFS_WATCH_STAT);

  // A write that lands on a capability word is dropped, but noted.
  assign ro_write = reg_wr && lk.hit;

  // Software clears the watch status by writing one to its flag bit.
  assign stat_clear = reg_wr && stat_sel && reg_wdata[frir_pkg::STAT_FLAG_BIT];

  // ---------------------------------------------------------------
  // Watch control
  // ---------------------------------------------------------------

  // Counting can be switched off when a driver probes the map on purpose.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      count_en_r <= frir_pkg::CTRL_COUNT_EN_RST;
    end else if (reg_wr && ctrl_sel) begin
      count_en_r <= reg_wdata[frir_pkg::CTRL_COUNT_EN_BIT];
    end
  end

  // ---------------------------------------------------------------
  // Watch status
  // ---------------------------------------------------------------

  // Saturates rather than wraps, so a large count is never mistaken for few.
  always_comb begin
    cnt_nxt = cnt_r;
    if (stat_clear) begin
      cnt_nxt = frir_pkg::STAT_CNT_RST;
    end
    if (ro_write && count_en_r && cnt_r != frir_pkg::STAT_CNT_MAX) begin
      cnt_nxt = stat_clear ? 16'h0001 : cnt_r + 16'h0001;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r <= frir_pkg::STAT_CNT_RST;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // A dropped write in the clearing cycle wins, so no event is lost.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      flag_r <= 1'b0;
    end else if (ro_write && count_en_r) begin
      flag_r <= 1'b1;
    end else if (stat_clear) begin
      flag_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------

  // Unmapped offsets and idle cycles both read as zero.
  always_comb begin
    rdata_nxt = 32'h00000000;
    if (reg_rd) begin
      if (lk.hit) begin
        rdata_nxt = lk.caps;
      end else if (ctrl_sel) begin
        rdata_nxt[frir_pkg::CTRL_COUNT_EN_BIT] = count_en_r;
      end else if (stat_sel) begin
        rdata_nxt[frir_pkg::STAT_FLAG_BIT] = flag_r;
        rdata_nxt[15:0] = cnt_r;
      end
    end
  end

  // Data stands for exactly the cycle after the read strobe.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_r <= 32'h00000000;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);

  // Read of one offset, answered one cycle later.
  sequence rd_at(logic [11:0] ofs);
    reg_rd && reg_addr == ofs;
  endsequence

  a_fmt0_mode1_value: assert property (rd_at(frir_pkg::OFS_FMT0_MODE1) |=> reg_rdata == 32'hFC000000)
    else $error("format 0 mode 1 capability read wrong");

  a_fmt0_mode5_value: assert property (rd_at(frir_pkg::OFS_FMT0_MODE5) |=> reg_rdata == 32'hFC000000)
    else $error("format 0 mode 5 capability read wrong");

  a_fmt0_mode6_value: assert property (rd_at(frir_pkg::OFS_FMT0_MODE6) |=> reg_rdata == 32'hF8000000)
    else $error("format 0 mode 6 capability read wrong");

  a_fmt1_mode2_value: assert property (rd_at(frir_pkg::OFS_FMT1_MODE2) |=> reg_rdata == 32'h3C000000)
    else $error("format 1 mode 2 capability read wrong");

  a_fmt1_mode5_value: assert property (rd_at(frir_pkg::OFS_FMT1_MODE5) |=> reg_rdata == 32'h78000000)
    else $error("format 1 mode 5 capability read wrong");

  a_fmt1_mode6_value: assert property (rd_at(frir_pkg::OFS_FMT1_MODE6) |=> reg_rdata == 32'h78000000)
    else $error("format 1 mode 6 capability read wrong");

  a_fmt1_mode7_value: assert property (rd_at(frir_pkg::OFS_FMT1_MODE7) |=> reg_rdata == 32'h70000000)
    else $error("format 1 mode 7 capability read wrong");

  // Any capability read leaves positions 8 to 31, the low 24 bits, clear.
  a_caps_rsvd_zero: assert property (reg_rd && lk.hit |=> (reg_rdata & 32'h00FFFFFF) == 32'h00000000)
    else $error("reserved capability positions read nonzero");

  // A write then a read of the same capability word returns the constant.
  a_caps_write_ignored: assert property (
    reg_wr && lk.hit ##1 reg_rd && reg_addr == $past(reg_addr) |=> reg_rdata == $past(lk.caps))
    else $error("capability word changed by a write");

  // Position 0, the slowest rate, sits in the top bit of the quadlet.
  a_pos0_is_msb: assert property (rd_at(frir_pkg::OFS_FMT0_MODE1) |=> reg_rdata[31] && !reg_rdata[0])
    else $error("position 0 not in the most significant bit");

  // Every answered capability bit lies in positions 0 to 5, the rates that some word offers.
  a_caps_bit_offered: assert property (reg_rd && lk.hit |=> (reg_rdata & ~32'hFC000000) == 32'h00000000 ||
    reg_rdata == 32'h3C000000)
    else $error("capability bit set outside the offered rates");

  // Read data is zero in any cycle that does not follow a read.
  a_rdata_idle_zero: assert property (!reg_rd |=> reg_rdata == 32'h00000000)
    else $error("read data not zero after an idle cycle");

  // A dropped write sets the watch flag even in a clearing cycle.
  a_flag_set_wins: assert property (ro_write && count_en_r |=> flag_r)
    else $error("watch flag missed a dropped write");

  cover property (rd_at(frir_pkg::OFS_FMT1_MODE7) ##1 rd_at(frir_pkg::OFS_FMT0_MODE1));
  cover property (reg_wr && lk.hit ##1 rd_at($past(reg_addr)));
  cover property (stat_clear ##1 !flag_r);
  cover property (reg_rd && !lk.hit && !ctrl_sel && !stat_sel);

endmodule

/* File: verilog/frir_pkg.sv */
// What this block does
// - Every capability bit reports one format, mode and frame rate combination.
// - A bit reads one when the combination is offered, zero otherwise.
// - Positions 0 to 7 mean 1.875 up to 240 fps; 8 to 31 reserved.
// - Format 0 mode 1 at 0x204 offers positions 0 to 5 only.
// - Format 0 mode 5 at 0x214 offers positions 0 to 5 only.
// - Format 0 mode 6 at 0x218 offers positions 0 to 4 only.
// - Format 1 mode 2 at 0x228 offers positions 2 to 5 only.
// - Format 1 mode 5 at 0x234 offers positions 1 to 4 only.
// - Format 1 mode 6 at 0x238 offers positions 1 to 4 only.
// - Format 1 mode 7 at 0x23C offers positions 1 to 3 only.
package frir_pkg;

  // ---------------------------------------------------------------
  // Bus geometry
  // ---------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [11:0] OFS_FMT0_MODE1 = 12'h204;
  localparam logic [11:0] OFS_FMT0_MODE5 = 12'h214;
  localparam logic [11:0] OFS_FMT0_MODE6 = 12'h218;
  localparam logic [11:0] OFS_FMT1_MODE2 = 12'h228;
  localparam logic [11:0] OFS_FMT1_MODE5 = 12'h234;
  localparam logic [11:0] OFS_FMT1_MODE6 = 12'h238;
  localparam logic [11:0] OFS_FMT1_MODE7 = 12'h23C;
  localparam logic [11:0] OFS_WATCH_CTRL = 12'h2F8;
  localparam logic [11:0] OFS_WATCH_STAT = 12'h2FC;

  // ---------------------------------------------------------------
  // Capability values, position 0 in bit 31
  // ---------------------------------------------------------------
  localparam logic [31:0] CAPS_FMT0_MODE1 = 32'hFC000000;
  localparam logic [31:0] CAPS_FMT0_MODE5 = 32'hFC000000;
  localparam logic [31:0] CAPS_FMT0_MODE6 = 32'hF8000000;
  localparam logic [31:0] CAPS_FMT1_MODE2 = 32'h3C000000;
  localparam logic [31:0] CAPS_FMT1_MODE5 = 32'h78000000;
  localparam logic [31:0] CAPS_FMT1_MODE6 = 32'h78000000;
  localparam logic [31:0] CAPS_FMT1_MODE7 = 32'h70000000;
  localparam logic [31:0] CAPS_RSVD_MASK = 32'h00FFFFFF;

  // ---------------------------------------------------------------
  // Watch registers: fields and reset values
  // ---------------------------------------------------------------
  localparam int CTRL_COUNT_EN_BIT = 0;
  localparam int STAT_FLAG_BIT = 31;
  localparam int STAT_CNT_W = 16;
  localparam logic CTRL_COUNT_EN_RST = 1'b1;
  localparam logic [15:0] STAT_CNT_RST = 16'h0000;
  localparam logic [15:0] STAT_CNT_MAX = 16'hFFFF;

  // Maps a word offset to its capability value; hit is zero off the map.
  function automatic logic [32:0] frir_caps_of(input logic [11:0] ofs);
    logic [32:0] r;
    r = {1'b1, 32'h00000000};
    case (ofs)
      OFS_FMT0_MODE1: r[31:0] = CAPS_FMT0_MODE1;
      OFS_FMT0_MODE5: r[31:0] = CAPS_FMT0_MODE5;
      OFS_FMT0_MODE6: r[31:0] = CAPS_FMT0_MODE6;
      OFS_FMT1_MODE2: r[31:0] = CAPS_FMT1_MODE2;
      OFS_FMT1_MODE5: r[31:0] = CAPS_FMT1_MODE5;
      OFS_FMT1_MODE6: r[31:0] = CAPS_FMT1_MODE6;
      OFS_FMT1_MODE7: r[31:0] = CAPS_FMT1_MODE7;
      default: r = 33'h000000000;
    endcase
    return r;
  endfunction

endpackage

/* File: verilog/frir_lookup_if.sv */
`timescale 1ns/100ps
// Carries an offset to the capability table and its answer back.
interface frir_lookup_if;
  logic [11:0] ofs;
  logic hit;
  logic [31:0] caps;
  modport requester (output ofs, input hit, input caps);
  modport table_side (input ofs, output hit, output caps);
endinterface

/* File: verilog/frir_caps_table.sv */
`timescale 1ns/100ps
// ---------------------------------------------------------------
// Constant capability table
// ---------------------------------------------------------------
module frir_caps_table (
  frir_lookup_if.table_side lk
);

  logic [32:0] entry;

  // Pure decode: the values are fixed by the sensor build, so no storage.
  always_comb begin
    entry = frir_pkg::frir_caps_of(lk.ofs);
  end

  // Reserved positions are forced low even if a table value were mistyped.
  assign lk.hit = entry[32];
  assign lk.caps = entry[31:0] & ~frir_pkg::CAPS_RSVD_MASK;

endmodule

/* File: test/frir_host_model.sv */
`timescale 1ns/100ps
// ---------------------------------------------------------------
// Host controller model for the register port
// ---------------------------------------------------------------
module frir_host_model (
  input wire logic core_clk,
  output logic [11:0] reg_addr,
  output logic [31:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [31:0] reg_rdata
);
  // Quiet bus at time zero, strobes low.
  initial begin
    reg_addr = 12'h000;
    reg_wdata = 32'h00000000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  // One-cycle write; released lines carry the inverse so a stale value never looks valid.
  task automatic bus_write(input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask

  // One-cycle read; the data are taken inside the following cycle, the only one where they stand.
  task automatic bus_read(input logic [11:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata;
  endtask

  // Write strobe followed with no gap by a read of the same word.
  task automatic bus_write_read(input logic [11:0] a, input logic [31:0] w, output logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= w;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    reg_wdata <= ~w;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata;
  endtask
endmodule

/* File: test/frir_regs_bench.sv */
`timescale 1ns/100ps
module frir_regs_bench;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata;
  int err_count = 0;
  int compares = 0;
  int cycles = 0;
  logic [11:0] ofs_tab [7] = '{12'h204, 12'h214, 12'h218, 12'h228, 12'h234, 12'h238, 12'h23C};
  int lo_tab [7] = '{0, 0, 0, 2, 1, 1, 1};
  int hi_tab [7] = '{5, 5, 4, 5, 4, 4, 3};

  // ---------------------------------------------------------------
  // Clock, instances and timeout
  // ---------------------------------------------------------------
  always #10 core_clk = ~core_clk;

  frir_regs uut (.core_clk(core_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  frir_host_model host (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  // The whole run needs well under a thousand cycles, so five thousand means a hang.
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      complete_run();
    end
  end

  // ---------------------------------------------------------------
  // Checking helpers
  // ---------------------------------------------------------------
  task automatic complete_run();
    if (err_count == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Rate position p sits in bit 31-p, so the slowest rate is the top bit.
  function automatic logic [31:0] caps_exp(input int lo, input int hi);
    logic [31:0] v;
    v = 32'h00000000;
    for (int p = lo; p <= hi; p++) begin
      v[31 - p] = 1'b1;
    end
    return v;
  endfunction

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic test_reset_state();
    logic [31:0] d;
    chk("rdata idle", reg_rdata, 32'h00000000);
    host.bus_read(12'h2F8, d);
    chk("ctrl reset", d, 32'h00000001);
    host.bus_read(12'h2FC, d);
    chk("status reset", d, 32'h00000000);
  endtask

  task automatic test_caps_read();
    logic [31:0] d;
    for (int i = 0; i < 7; i++) begin
      host.bus_read(ofs_tab[i], d);
      chk("caps", d, caps_exp(lo_tab[i], hi_tab[i]));
      chk("caps reserved", d & 32'h00FFFFFF, 32'h00000000);
    end
    @(posedge core_clk);
    #1;
    chk("rdata after read", reg_rdata, 32'h00000000);
  endtask

  // Writes of all ones and all zeros must leave every table word as it was.
  task automatic test_write_blocked();
    logic [31:0] d;
    for (int i = 0; i < 7; i++) begin
      host.bus_write(ofs_tab[i], (i % 2 == 0) ? 32'hFFFFFFFF : 32'h00000000);
      host.bus_read(ofs_tab[i], d);
      chk("caps after write", d, caps_exp(lo_tab[i], hi_tab[i]));
    end
    host.bus_read(12'h2FC, d);
    chk("status count", d, 32'h80000007);
    host.bus_write(12'h2FC, 32'h80000000);
    host.bus_read(12'h2FC, d);
    chk("status cleared", d, 32'h00000000);
    host.bus_write(12'h2F8, 32'h00000000);
    host.bus_write(12'h23C, 32'hFFFFFFFF);
    host.bus_read(12'h2FC, d);
    chk("status disabled", d, 32'h00000000);
    host.bus_write_read(12'h228, 32'hFFFFFFFF, d);
    chk("caps write then read", d, caps_exp(2, 5));
    host.bus_write(12'h2F8, 32'h00000001);
  endtask

  // Unmapped and misaligned places read zero and take no writes.
  task automatic test_unmapped();
    logic [31:0] d;
    logic [11:0] miss [3] = '{12'h200, 12'h206, 12'h240};
    for (int i = 0; i < 3; i++) begin
      host.bus_write(miss[i], 32'hFFFFFFFF);
      host.bus_read(miss[i], d);
      chk("unmapped", d, 32'h00000000);
    end
    host.bus_read(12'h2FC, d);
    chk("status unmapped", d, 32'h00000000);
    host.bus_read(12'h23C, d);
    chk("caps 23C", d, caps_exp(1, 3));
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (16) @(posedge core_clk);
    arst_n <= 1'b1;
    @(posedge core_clk);
    #1;
    test_reset_state();
    test_caps_read();
    test_write_blocked();
    test_unmapped();
    complete_run();
  end
endmodule
